// *** logic/access_check.sv ***
// Instruction and port permission checks for the current mode
`timescale 1ns/100ps
module access_check (
  input  wire logic                  compat,
  input  wire logic [1:0]            io_privilege_level,
  input  wire logic [1:0]            current_privilege_level,
  input  wire logic                  instr_valid,
  input  wire mode_ctl_pkg::instr_t  instr_code,
  input  wire logic                  io_denied,
  input  wire logic                  page_absent,
  input  wire logic                  mode_extension_enable,
  input  wire logic                  redirect_ok,
  output wire logic                  gp_fault,
  output wire logic                  page_fault,
  output wire logic                  redirect
);

  wire logic io_privilege_level_sens;
  wire logic io_op;
  wire logic is_int;
  wire logic int_redir;
  wire logic sens_gp;
  wire logic halt_gp;
  wire logic io_gp;

  // Instruction classes
  assign io_privilege_level_sens = instr_code inside {mode_ctl_pkg::clear_interrupt_instr,
                     mode_ctl_pkg::set_interrupt_instr, mode_ctl_pkg::push_flags_instr,
                     mode_ctl_pkg::pop_flags_instr, mode_ctl_pkg::software_interrupt_instr,
                     mode_ctl_pkg::interrupt_return_instr};
  assign io_op     = instr_code inside {mode_ctl_pkg::port_in_instr,
                     mode_ctl_pkg::port_out_instr, mode_ctl_pkg::string_input_instr,
                     mode_ctl_pkg::string_output_instr};
  assign is_int    = instr_code == mode_ctl_pkg::software_interrupt_instr;

  // Redirected software interrupts stay in compatibility mode
  assign int_redir = compat & is_int & mode_extension_enable & redirect_ok;
  assign sens_gp   = compat & io_privilege_level_sens & (io_privilege_level != mode_ctl_pkg::PL_USER) & ~int_redir;
  assign halt_gp   = compat & (instr_code == mode_ctl_pkg::halt_instr);
  // Bitmap always consulted in compat; privilege bypass only outside it
  assign io_gp     = io_op & io_denied & (compat | (current_privilege_level > io_privilege_level));

  assign gp_fault   = instr_valid & (sens_gp | halt_gp | io_gp);
  assign page_fault = instr_valid & compat & page_absent & ~gp_fault;
  assign redirect   = instr_valid & int_redir & ~gp_fault;

endmodule : access_check

// *** logic/legacy_mode_ctl.sv ***
// Legacy compatibility mode entry, exit and permission control
`timescale 1ns/100ps
module legacy_mode_ctl (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output wire logic                  pready,
  output wire logic                  pslverr,
  // Pin and core events
  input  wire logic                  warm_restart_pin,
  input  wire logic                  prot_enable,
  input  wire logic                  task_switch,
  input  wire logic [31:0]           tss_flags,
  input  wire logic                  tss_wide,
  input  wire logic                  interrupt_return_instr_exec,
  input  wire logic [31:0]           stack_flags,
  input  wire logic                  pop_flags_wr,
  input  wire logic [31:0]           pop_flags_val,
  input  wire logic                  event_take,
  input  wire logic [7:0]            event_vector,
  input  wire logic                  seg_load,
  input  wire logic [15:0]           seg_selector,
  input  wire logic [31:0]           desc_base,
  input  wire logic [1:0]            prot_cpl,
  input  wire logic                  instr_valid,
  input  wire mode_ctl_pkg::instr_t  instr_code,
  input  wire logic                  io_denied,
  input  wire logic                  page_absent,
  input  wire logic                  redirect_ok,
  // Results
  output wire logic                  compat_mode,
  output wire logic                  real_mode,
  output wire logic [1:0]            current_privilege_level,
  output logic      [31:0]           seg_base,
  output logic                       dispatch_req,
  output logic      [7:0]            dispatch_vector,
  output logic                       redirect_req
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  mode_ctl_pkg::mode_t mode_ff;
  mode_ctl_pkg::mode_t nxt_mode;
  logic [31:0]         flags_ff;
  logic [31:0]         nxt_flags;
  logic                vme_ff;
  logic [15:0]         fcount_ff;
  logic                pin_s1_ff;
  logic                pin_s2_ff;
  logic                pin_s3_ff;
  logic                pin_lvl_ff;

  wire logic       gp_fault;
  wire logic       page_fault;
  wire logic       redirect;
  wire logic       warm_edge;
  wire logic       take;
  wire logic       interrupt_return_instr_ok;
  wire logic       pop_ok;
  wire logic       switch_ok;
  wire logic [31:0] tss_image;
  wire logic [31:0] pop_image;
  wire logic       nxt_vm;
  wire logic [1:0] io_privilege_level;

  ////////////////////////////////////////////////////////////////////////////////
  // Warm restart pin: three stages, a change counts once stages two and three agree

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_s1_ff  <= 1'b0;
      pin_s2_ff  <= 1'b0;
      pin_s3_ff  <= 1'b0;
      pin_lvl_ff <= 1'b0;
    end else begin
      pin_s1_ff <= warm_restart_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      if (pin_s2_ff == pin_s3_ff) begin
        pin_lvl_ff <= pin_s3_ff;
      end
    end
  end

  assign warm_edge = (pin_s2_ff == pin_s3_ff) & pin_s3_ff & ~pin_lvl_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Single compatibility indication and derived privilege

  assign compat_mode = mode_ff == mode_ctl_pkg::compat_st;
  assign real_mode   = mode_ff == mode_ctl_pkg::real_st;
  assign io_privilege_level        = flags_ff[mode_ctl_pkg::IO_PRIVILEGE_LEVEL_HI:mode_ctl_pkg::IO_PRIVILEGE_LEVEL_LO];
  // Compat code is always user level; real mode has no rings
  assign current_privilege_level = compat_mode ? mode_ctl_pkg::PL_USER :
               (real_mode ? mode_ctl_pkg::PL_KERNEL : prot_cpl);

  access_check u_check (
    .compat      (compat_mode),
    .io_privilege_level        (io_privilege_level),
    .current_privilege_level         (current_privilege_level),
    .instr_valid (instr_valid),
    .instr_code  (instr_code),
    .io_denied   (io_denied),
    .page_absent (page_absent),
    .mode_extension_enable         (vme_ff),
    .redirect_ok (redirect_ok),
    .gp_fault    (gp_fault),
    .page_fault  (page_fault),
    .redirect    (redirect)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Flags image selection

  // Any fault or external event leaves the mode; apart from a warm restart nothing else may
  assign take      = gp_fault | page_fault | event_take;
  // Task switches are refused from inside compat mode: exit is by event first
  assign switch_ok = task_switch & ~compat_mode;
  assign interrupt_return_instr_ok   = interrupt_return_instr_exec & ~gp_fault;
  assign pop_ok    = pop_flags_wr & ~gp_fault;
  // Narrow segment carries no upper word, so the mode flag reads as zero
  assign tss_image = tss_wide ? tss_flags : (tss_flags & mode_ctl_pkg::LOW_HALF);
  // Pop keeps the live mode flag whatever the image says
  assign pop_image = (pop_flags_val & ~mode_ctl_pkg::VM_MASK) |
                     (flags_ff & mode_ctl_pkg::VM_MASK);

  // Priority: restart, event, task switch, return, pop
  always_comb begin
    nxt_flags = flags_ff;
    if (warm_edge) begin
      nxt_flags = mode_ctl_pkg::FLAGS_RST;
    end else if (take) begin
      nxt_flags = flags_ff & ~(mode_ctl_pkg::VM_MASK | mode_ctl_pkg::NT_MASK);
    end else if (switch_ok) begin
      nxt_flags = tss_image;
    end else if (interrupt_return_instr_ok) begin
      if (compat_mode) begin
        nxt_flags = (stack_flags & ~mode_ctl_pkg::VM_MASK) |
                    (flags_ff & mode_ctl_pkg::VM_MASK);
      end else if (flags_ff[mode_ctl_pkg::NT_BIT]) begin
        nxt_flags = tss_image;
      end else begin
        nxt_flags = stack_flags;
      end
    end else if (pop_ok) begin
      nxt_flags = pop_image;
    end
  end

  assign nxt_vm = nxt_flags[mode_ctl_pkg::VM_BIT];

  // Mode follows the new flag; real mode only left by the enable strobe
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      mode_ctl_pkg::real_st: begin
        if (prot_enable & ~warm_edge) begin
          nxt_mode = mode_ctl_pkg::prot_st;
        end
      end
      mode_ctl_pkg::prot_st, mode_ctl_pkg::compat_st: begin
        if (warm_edge) begin
          nxt_mode = mode_ctl_pkg::real_st;
        end else if (nxt_vm) begin
          nxt_mode = mode_ctl_pkg::compat_st;
        end else begin
          nxt_mode = mode_ctl_pkg::prot_st;
        end
      end
    endcase
  end

  // Flags and mode registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags_ff <= mode_ctl_pkg::FLAGS_RST;
      mode_ff  <= mode_ctl_pkg::real_st;
    end else begin
      flags_ff <= nxt_flags;
      mode_ff  <= nxt_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Segment base: uses the flag value being loaded this cycle

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seg_base <= '0;
    end else if (seg_load) begin
      seg_base <= (nxt_vm & (nxt_mode == mode_ctl_pkg::compat_st)) ?
                  mode_ctl_pkg::legacy_base(seg_selector) : desc_base;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Dispatch to the descriptor table; own faults win over external events

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dispatch_req    <= 1'b0;
      dispatch_vector <= '0;
      redirect_req    <= 1'b0;
    end else begin
      dispatch_req <= take & ~warm_edge;
      redirect_req <= redirect & ~warm_edge & ~event_take;
      if (gp_fault) begin
        dispatch_vector <= mode_ctl_pkg::GP_VEC;
      end else if (page_fault) begin
        dispatch_vector <= mode_ctl_pkg::PF_VEC;
      end else if (event_take) begin
        dispatch_vector <= event_vector;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data captured in the setup cycle

  wire logic setup;
  wire logic wr_acc;
  wire logic hit;
  wire logic [31:0] status_word;
  logic [31:0] rd_mux;

  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pwrite;
  assign hit     = paddr inside {mode_ctl_pkg::REG_CTRL, mode_ctl_pkg::REG_STATUS,
                                 mode_ctl_pkg::REG_FLAGS, mode_ctl_pkg::REG_FCOUNT};
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign status_word = ({31'h0, compat_mode} << mode_ctl_pkg::STAT_COMPAT) |
                       ({31'h0, real_mode} << mode_ctl_pkg::STAT_REAL) |
                       ({30'h0, current_privilege_level} << mode_ctl_pkg::STAT_CPL_LO) |
                       ({30'h0, io_privilege_level} << mode_ctl_pkg::STAT_IO_PRIVILEGE_LEVEL_LO);

  // Read selection
  always_comb begin
    unique case (paddr)
      mode_ctl_pkg::REG_CTRL:   rd_mux = {31'h0, vme_ff} << mode_ctl_pkg::CTRL_VME;
      mode_ctl_pkg::REG_STATUS: rd_mux = status_word;
      mode_ctl_pkg::REG_FLAGS:  rd_mux = flags_ff;
      mode_ctl_pkg::REG_FCOUNT: rd_mux = {16'h0, fcount_ff};
      default:                  rd_mux = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= '0;
    end else if (setup & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Extension enable and fault counter; a new fault beats a software clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vme_ff    <= 1'b0;
      fcount_ff <= '0;
    end else begin
      if (wr_acc & (paddr == mode_ctl_pkg::REG_CTRL)) begin
        vme_ff <= pwdata[mode_ctl_pkg::CTRL_VME];
      end
      if (gp_fault) begin
        fcount_ff <= (wr_acc & (paddr == mode_ctl_pkg::REG_FCOUNT)) ? 16'h0001 :
                     fcount_ff + 16'h0001;
      end else if (wr_acc & (paddr == mode_ctl_pkg::REG_FCOUNT)) begin
        fcount_ff <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  wire logic quiet;
  assign quiet = ~warm_edge & ~take;

  enter_call_a: assert property (
    quiet & task_switch & ~compat_mode & ~real_mode & tss_wide &
    tss_flags[mode_ctl_pkg::VM_BIT] |=> compat_mode & (current_privilege_level == mode_ctl_pkg::PL_USER))
    else $error("task switch did not enter compat mode");

  narrow_tss_a: assert property (
    quiet & switch_ok & ~tss_wide |=> ~flags_ff[mode_ctl_pkg::VM_BIT] & ~compat_mode)
    else $error("narrow segment left mode flag set");

  stay_compat_a: assert property (
    compat_mode & quiet |=> compat_mode)
    else $error("compat mode left without an event");

  halt_gp_a: assert property (
    compat_mode & instr_valid & (instr_code == mode_ctl_pkg::halt_instr) & ~warm_edge
    |=> dispatch_req & (dispatch_vector == mode_ctl_pkg::GP_VEC) & ~compat_mode)
    else $error("halt did not fault with vector 13");

  io_privilege_level_sens_a: assert property (
    compat_mode & instr_valid & (io_privilege_level != mode_ctl_pkg::PL_USER) & ~warm_edge &
    (instr_code == mode_ctl_pkg::clear_interrupt_instr) |=> dispatch_req)
    else $error("sensitive instruction not faulted");

  io_free_a: assert property (
    compat_mode & instr_valid & (instr_code == mode_ctl_pkg::port_out_instr) &
    ~io_denied & ~page_absent & ~event_take |=> ~dispatch_req)
    else $error("permitted port faulted on io level");

  io_bitmap_a: assert property (
    compat_mode & instr_valid & (instr_code == mode_ctl_pkg::port_in_instr) &
    io_denied & ~warm_edge |=> dispatch_req & (dispatch_vector == mode_ctl_pkg::GP_VEC))
    else $error("denied port not faulted");

  pop_vm_a: assert property (
    pop_flags_wr & ~take & ~warm_edge & ~switch_ok & ~interrupt_return_instr_exec
    |=> flags_ff[mode_ctl_pkg::VM_BIT] == $past(flags_ff[mode_ctl_pkg::VM_BIT]))
    else $error("flag pop changed the mode flag");

  seg_legacy_a: assert property (
    compat_mode & quiet & seg_load
    |=> seg_base == mode_ctl_pkg::legacy_base($past(seg_selector)))
    else $error("legacy segment base wrong");

  warm_exit_a: assert property (
    warm_edge |=> real_mode & ~compat_mode ##1 real_mode)
    else $error("warm restart did not enter real mode");

  event_exit_a: assert property (
    compat_mode & event_take & ~warm_edge |=> ~compat_mode & dispatch_req)
    else $error("event did not leave compat mode");

  enter_cov: cover property ($rose(compat_mode));
  halt_cov: cover property (compat_mode & instr_valid &
                            (instr_code == mode_ctl_pkg::halt_instr));
  redir_cov: cover property (redirect_req);
  warm_cov: cover property (compat_mode & warm_edge);

endmodule : legacy_mode_ctl

// *** logic/mode_ctl_pkg.sv ***
// Shared constants and types for the legacy mode control block
package mode_ctl_pkg;

  // Flags register layout
  localparam int          VM_BIT    = 17;
  localparam int          NT_BIT    = 14;
  localparam int          IO_PRIVILEGE_LEVEL_LO   = 12;
  localparam int          IO_PRIVILEGE_LEVEL_HI   = 13;
  localparam logic [31:0] VM_MASK   = 32'h0002_0000;
  localparam logic [31:0] NT_MASK   = 32'h0000_4000;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
  localparam logic [31:0] LOW_HALF  = 32'h0000_ffff;

  // Privilege levels
  localparam logic [1:0] PL_USER   = 2'h3;
  localparam logic [1:0] PL_KERNEL = 2'h0;

  // Exception vectors
  localparam logic [7:0] GP_VEC = 8'h0d;
  localparam logic [7:0] PF_VEC = 8'h0e;

  // Register byte addresses on the APB port
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FLAGS  = 8'h08;
  localparam logic [7:0] REG_FCOUNT = 8'h0c;

  // Field positions inside the control and status words
  localparam int CTRL_VME    = 0;
  localparam int STAT_COMPAT = 0;
  localparam int STAT_REAL   = 1;
  localparam int STAT_CPL_LO = 2;
  localparam int STAT_IO_PRIVILEGE_LEVEL_LO = 4;

  typedef enum logic [3:0] {
    other_instr,
    halt_instr,
    clear_interrupt_instr,
    set_interrupt_instr,
    push_flags_instr,
    pop_flags_instr,
    software_interrupt_instr,
    interrupt_return_instr,
    port_in_instr,
    port_out_instr,
    string_input_instr,
    string_output_instr
  } instr_t;

  typedef enum logic [1:0] {real_st, prot_st, compat_st} mode_t;

  // Legacy translation: base is the selector times sixteen
  function automatic logic [31:0] legacy_base(input logic [15:0] sel);
    return {12'h000, sel, 4'h0};
  endfunction : legacy_base

endpackage : mode_ctl_pkg

// *** verif/monitor_model.sv ***
// Behavioural monitor that returns from a handler after a dispatch
`timescale 1ns/100ps
module monitor_model (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        dispatch_req,
  input  wire logic        resume_en,
  input  wire logic        interrupt_return_instr_now,
  input  wire logic [3:0]  delay_cycles,
  input  wire logic [31:0] resume_flags,
  output logic             interrupt_return_instr_exec,
  output logic [31:0]      stack_flags
);
  int cnt;

  ////////////////////////////////////////////////////////////////////////
  // Handler return after a programmable delay; the image toggles when idle
  // so a stale value is never mistaken for a real one
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt <= 0;
      interrupt_return_instr_exec <= 1'b0;
      stack_flags <= 32'h0000_0000;
    end else begin
      interrupt_return_instr_exec <= 1'b0;
      stack_flags <= ~stack_flags;
      if (dispatch_req && resume_en) begin
        cnt <= delay_cycles;
      end else if (interrupt_return_instr_now) begin
        // Plain stack image, so a nested return must take the segment image
        interrupt_return_instr_exec <= 1'b1;
        stack_flags <= 32'h0000_0000;
      end else if (cnt == 1) begin
        cnt <= 0;
        interrupt_return_instr_exec <= 1'b1;
        stack_flags <= resume_flags;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : monitor_model

// *** verif/testbench.sv ***
// Self-checking bench for the legacy mode control block
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, event_vector = 0;
  logic [31:0] pwdata = 0, tss_flags = 0, pop_flags_val = 0, desc_base = 0;
  logic [31:0] resume_flags = 0, prdata, seg_base, stack_flags, rd;
  logic warm_restart_pin = 0, prot_enable = 0, task_switch = 0, tss_wide = 0;
  logic pop_flags_wr = 0, event_take = 0, seg_load = 0, instr_valid = 0;
  logic io_denied = 0, page_absent = 0, redirect_ok = 0, resume_en = 0, er;
  logic pready, pslverr, interrupt_return_instr_exec, compat_mode, real_mode, dispatch_req;
  logic redirect_req, interrupt_return_instr_now = 0;
  logic [15:0] seg_selector = 0;
  logic [1:0] prot_cpl = 2'h1, current_privilege_level;
  logic [7:0] dispatch_vector;
  logic [3:0] delay_cycles = 0;
  mode_ctl_pkg::instr_t instr_code = mode_ctl_pkg::other_instr;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, gp = 0;

  legacy_mode_ctl dut (.*);
  monitor_model partner (.*);

  always #10 sys_clk = ~sys_clk;

  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////
  // APB master: request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Drop every pulse at the edge that samples it, then let outputs settle
  task automatic pulse_end;
    @(posedge sys_clk);
    task_switch <= 1'b0;
    seg_load <= 1'b0;
    instr_valid <= 1'b0;
    event_take <= 1'b0;
    pop_flags_wr <= 1'b0;
    prot_enable <= 1'b0;
    interrupt_return_instr_now <= 1'b0;
    #1;
  endtask : pulse_end

  // Task switch with a segment load in the same cycle
  task automatic enter(input logic [1:0] pl, input logic wide, input logic [31:0] fl);
    @(posedge sys_clk);
    task_switch <= 1'b1;
    tss_wide <= wide;
    tss_flags <= fl | {18'h0, pl, 12'h0};
    seg_load <= 1'b1;
    seg_selector <= 16'h1234;
    desc_base <= 32'h00ab_c000;
    pulse_end();
  endtask : enter

  task automatic instr(input mode_ctl_pkg::instr_t c, input logic den, abs, rok);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_code <= c;
    io_denied <= den;
    page_absent <= abs;
    redirect_ok <= rok;
    pulse_end();
  endtask : instr

  task automatic fault(input logic [7:0] v);
    chk("dispatch", dispatch_req, 1);
    chk("vector", dispatch_vector, v);
    chk("compat after fault", compat_mode, 0);
    if (v == mode_ctl_pkg::GP_VEC) gp++;
  endtask : fault

  mode_ctl_pkg::instr_t sens[7] = '{mode_ctl_pkg::halt_instr,
    mode_ctl_pkg::clear_interrupt_instr, mode_ctl_pkg::set_interrupt_instr,
    mode_ctl_pkg::push_flags_instr, mode_ctl_pkg::pop_flags_instr,
    mode_ctl_pkg::software_interrupt_instr, mode_ctl_pkg::interrupt_return_instr};

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(0, mode_ctl_pkg::REG_STATUS, 0);
    chk("status reset", rd, 32'h0000_0002);
    chk("pready", pready, 1);
    apb(0, mode_ctl_pkg::REG_FLAGS, 0);
    chk("flags reset", rd, mode_ctl_pkg::FLAGS_RST);
    apb(0, 8'h10, 0);
    chk("unmapped err", er, 1);
    apb(1, mode_ctl_pkg::REG_CTRL, 32'h1);
    apb(0, mode_ctl_pkg::REG_CTRL, 0);
    chk("ctrl", rd, 32'h1);
    apb(1, mode_ctl_pkg::REG_CTRL, 32'h0);
    @(posedge sys_clk);
    prot_enable <= 1'b1;
    pulse_end();
    chk("cpl prot", current_privilege_level, 2'h1);
    // A narrow image cannot carry the mode flag, so the base is the descriptor's
    enter(2'h3, 1'b0, mode_ctl_pkg::VM_MASK);
    chk("narrow", compat_mode, 0);
    chk("base prot", seg_base, 32'h00ab_c000);
    enter(2'h3, 1'b1, mode_ctl_pkg::VM_MASK);
    chk("compat", compat_mode, 1);
    chk("base legacy", seg_base, 32'h0001_2340);
    apb(0, mode_ctl_pkg::REG_STATUS, 0);
    chk("status compat", rd, 32'h0000_003d);
    @(posedge sys_clk);
    pop_flags_wr <= 1'b1;
    pop_flags_val <= 32'h0;
    pulse_end();
    chk("pop", compat_mode, 1);
    enter(2'h3, 1'b1, 32'h0);
    chk("switch in compat", compat_mode, 1);
    instr(mode_ctl_pkg::port_out_instr, 1, 0, 0);
    fault(mode_ctl_pkg::GP_VEC);
    for (int i = 0; i < 7; i++) begin
      enter(2'h0, 1'b1, mode_ctl_pkg::VM_MASK);
      chk("switch away", compat_mode, 1);
      instr(sens[i], 0, 0, 0);
      fault(mode_ctl_pkg::GP_VEC);
    end
    enter(2'h0, 1'b1, mode_ctl_pkg::VM_MASK);
    instr(mode_ctl_pkg::port_in_instr, 1, 0, 0);
    fault(mode_ctl_pkg::GP_VEC);
    enter(2'h0, 1'b1, mode_ctl_pkg::VM_MASK);
    instr(mode_ctl_pkg::string_input_instr, 0, 0, 0);
    chk("io low pl", dispatch_req, 0);
    instr(mode_ctl_pkg::string_output_instr, 0, 0, 0);
    chk("io out low pl", dispatch_req, 0);
    apb(1, mode_ctl_pkg::REG_CTRL, 32'h1);
    instr(mode_ctl_pkg::software_interrupt_instr, 0, 0, 1);
    chk("redirect", redirect_req, 1);
    chk("stay compat", compat_mode, 1);
    apb(1, mode_ctl_pkg::REG_CTRL, 32'h0);
    instr(mode_ctl_pkg::other_instr, 0, 1, 0);
    fault(mode_ctl_pkg::PF_VEC);
    apb(0, mode_ctl_pkg::REG_FCOUNT, 0);
    chk("gp count", rd & mode_ctl_pkg::LOW_HALF, gp);
    apb(1, mode_ctl_pkg::REG_FCOUNT, 32'h0);
    apb(0, mode_ctl_pkg::REG_FCOUNT, 0);
    chk("gp clear", rd & mode_ctl_pkg::LOW_HALF, 0);
    // Nested return from a protected task loads the segment image
    enter(2'h3, 1'b1, mode_ctl_pkg::NT_MASK);
    chk("nested prot", compat_mode, 0);
    @(posedge sys_clk);
    tss_flags <= mode_ctl_pkg::VM_MASK;
    interrupt_return_instr_now <= 1'b1;
    pulse_end();
    @(posedge sys_clk);
    #1;
    chk("nested return", compat_mode, 1);
    // Monitor returns both promptly and slowly
    for (int d = 1; d < 8; d += 5) begin
      @(posedge sys_clk);
      resume_en <= 1'b1;
      delay_cycles <= 4'(d);
      resume_flags <= mode_ctl_pkg::VM_MASK;
      event_take <= 1'b1;
      event_vector <= 8'h20;
      pulse_end();
      fault(8'h20);
      for (int w = 0; w < 20 && compat_mode !== 1'b1; w++) @(posedge sys_clk);
      #1;
      chk("resume", compat_mode, 1);
    end
    @(posedge sys_clk);
    resume_en <= 1'b0;
    warm_restart_pin <= 1'b1;
    for (int w = 0; w < 8 && real_mode !== 1'b1; w++) @(posedge sys_clk);
    #1;
    chk("warm real", real_mode, 1);
    chk("warm compat", compat_mode, 0);
    warm_restart_pin <= 1'b0;
    summarize();
  end
endmodule : testbench
